// ==== verilog/pdm_pkg.sv ====
// Shared constants, types and decode helpers for the power-down controller
package pdm_pkg;

   // ***************************************************************
   // Register map (byte addresses on the Wishbone bus)
   // ***************************************************************
   localparam logic [7:0] ADR_SYSCTL = 8'h00;
   localparam logic [7:0] ADR_CLKDIV = 8'h04;
   localparam logic [7:0] ADR_MODSTBY_HI = 8'h08;
   localparam logic [7:0] ADR_MODSTBY_LO = 8'h0c;
   localparam logic [7:0] ADR_STATUS = 8'h10;

   // ***************************************************************
   // Reset values and bits that always read as one
   // ***************************************************************
   localparam logic [7:0] SYSCTL_RST = 8'h09;
   localparam logic [7:0] CLKDIV_RST = 8'hfc;
   localparam logic [7:0] CLKDIV_ONES = 8'hfc;
   localparam logic [7:0] MODSTBY_HI_RST = 8'h78;
   localparam logic [7:0] MODSTBY_HI_ONES = 8'h78;
   localparam logic [7:0] MODSTBY_LO_RST = 8'h00;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int HI_CLK_STOP_BIT = 7;
   localparam int LO_DMA_BIT = 7;
   localparam int LO_DRAM_BIT = 5;
   localparam int LO_T16_BIT = 4;
   localparam int LO_T8A_BIT = 3;
   localparam int LO_T8B_BIT = 2;
   localparam int LO_ADC_BIT = 0;
   localparam int STAT_BUSY_BIT = 3;

   // Gated module indices on the standby vectors
   localparam int MOD_SER0 = 0;
   localparam int MOD_SER1 = 1;
   localparam int MOD_SER2 = 2;
   localparam int MOD_DMA = 3;
   localparam int MOD_DRAM = 4;
   localparam int MOD_T16 = 5;
   localparam int MOD_T8A = 6;
   localparam int MOD_T8B = 7;
   localparam int MOD_ADC = 8;
   localparam int NUM_MODS = 9;
   localparam int SETTLE_W = 19;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [2:0] {
      PDM_RUN, PDM_SLEEP, PDM_SW_STANDBY_INPUT_PIN, PDM_SETTLE, PDM_HW_STANDBY_INPUT_PIN
   } pdm_mode_type;

   // System control register layout, bit 7 first
   typedef struct packed {
      logic standby_select;
      logic [2:0] settle_time_select;
      logic rsv3;
      logic nmi_edge_select;
      logic port_hold;
      logic rsv0;
   } pdm_sysctl_type;

   // wake wait table
   // Settle wait in divided clock states; the illegal code gets the longest wait
   function automatic logic [SETTLE_W-1:0] settle_states(input logic [2:0] code);
      unique case (code)
         3'h0: settle_states = 19'h02000;
         3'h1: settle_states = 19'h04000;
         3'h2: settle_states = 19'h08000;
         3'h3: settle_states = 19'h10000;
         3'h4: settle_states = 19'h20000;
         3'h5: settle_states = 19'h40000;
         3'h6: settle_states = 19'h00400;
         3'h7: settle_states = 19'h40000;
      endcase
   endfunction

endpackage

// ==== verilog/pdm_settle_timer.sv ====
// Oscillator settling wait counter for wake from software standby
module pdm_settle_timer
   import pdm_pkg::*;
#(
   parameter int SHIFT = 0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic start_i,
   input wire logic [2:0] code_i,
   // Status
   output logic busy_o,
   output logic done_o
);

   logic [SETTLE_W-1:0] cnt_r;
   logic [SETTLE_W-1:0] len_r;
   logic [SETTLE_W-1:0] elapsed_r;
   logic [SETTLE_W-1:0] len_nxt;

   // Shift only shortens simulation; never below one state
   always_comb begin
      len_nxt = settle_states(code_i) >> SHIFT;
      if (len_nxt == '0) begin
         len_nxt = 19'h00001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         len_r <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (start_i) begin
         cnt_r <= len_nxt - 19'h00001;
         len_r <= len_nxt;
         busy_o <= 1'b1;
         done_o <= 1'b0;
      end else if (busy_o && cnt_r == '0) begin
         busy_o <= 1'b0;
         done_o <= 1'b1;
      end else begin
         cnt_r <= busy_o ? cnt_r - 19'h00001 : cnt_r;
         done_o <= 1'b0;
      end
   end

   // Cycles seen busy, read only by the check below
   always_ff @(posedge clk_i) begin
      if (rst_i || start_i) begin
         elapsed_r <= '0;
      end else if (busy_o) begin
         elapsed_r <= elapsed_r + 19'h00001;
      end
   end

   a_settle_len: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(done_o) |-> elapsed_r == len_r)
      else $error("settle wait length differs from selected count");

endmodule

// ==== verilog/pdm_mod_gate.sv ====
// Per-module clock gate, held reset and register access block
module pdm_mod_gate
   import pdm_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Standby requests
   input wire logic [NUM_MODS-1:0] standby_i,
   input wire logic [NUM_MODS-1:0] stop_i,
   input wire logic [NUM_MODS-1:0] reset_i,
   // Module register access
   input wire logic [NUM_MODS-1:0] periph_sel_i,
   input wire logic periph_we_i,
   input wire logic [7:0] periph_rdata_i,
   // Module controls
   output logic [NUM_MODS-1:0] mod_clk_en_o,
   output logic [NUM_MODS-1:0] mod_rst_o,
   output logic periph_we_o,
   output logic [7:0] periph_rdata_o
);

   logic blocked;

   assign blocked = |(periph_sel_i & standby_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mod_clk_en_o <= '1;
         mod_rst_o <= '1;
      end else begin
         mod_clk_en_o <= ~(standby_i | stop_i);
         mod_rst_o <= standby_i | reset_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_we_o <= 1'b0;
         periph_rdata_o <= 8'hff;
      end else begin
         periph_we_o <= periph_we_i && !blocked;
         periph_rdata_o <= blocked ? 8'hff : periph_rdata_i;
      end
   end

   a_gate_halt: assert property (@(posedge clk_i) disable iff (rst_i)
      (standby_i != '0) |=> ((mod_clk_en_o | ~mod_rst_o) & $past(standby_i)) == '0)
      else $error("module in standby still clocked or released");

   a_access_ones: assert property (@(posedge clk_i) disable iff (rst_i)
      blocked |=> periph_rdata_o == 8'hff && !periph_we_o)
      else $error("standby module register not blocked");

endmodule

// ==== verilog/pdm_power_ctrl.sv ====
// Power-down controller: sleep, software standby, settle wait, module standby
// ***************************************************************
module pdm_power_ctrl
   import pdm_pkg::*;
#(
   parameter int SETTLE_SHIFT = 0
) (
   // Clock and reset pin
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // CPU and wake sources
   input wire logic standby_pin_n_i,
   input wire logic halt_exec_i,
   input wire logic sleep_wake_i,
   input wire logic standby_input_pin_wake_i,
   output logic cpu_clk_en_o,
   output logic int_start_o,
   output logic osc_run_o,
   // Chip wide controls
   output logic refresh_clear_o,
   output logic port_hold_o,
   output logic nmi_edge_select_o,
   output logic [1:0] clock_divide_o,
   output logic clk_out_oe_o,
   output logic clk_out_high_o,
   // Gated modules
   input wire logic [NUM_MODS-1:0] periph_sel_i,
   input wire logic periph_we_i,
   input wire logic [7:0] periph_rdata_i,
   output logic [NUM_MODS-1:0] mod_clk_en_o,
   output logic [NUM_MODS-1:0] mod_rst_o,
   output logic periph_we_o,
   output logic [7:0] periph_rdata_o
);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ***************************************************************
   // Declarations
   // ***************************************************************
   pdm_mode_type state_r, state_nxt;
   pdm_sysctl_type sysctl_r;
   logic [7:0] clkdiv_r;
   logic [7:0] modstby_hi_r;
   logic [7:0] modstby_lo_r;
   logic bus_req, bus_commit, wr_commit;
   logic settle_start, settle_busy, settle_done;
   logic hw_clear;
   logic [NUM_MODS-1:0] standby_vec, stop_vec, reset_vec;
   logic [7:0] rd_byte;

   // Hardware standby clears the same registers as the reset pin
   assign hw_clear = rst_i || !standby_pin_n_i;

   // ***************************************************************
   // Wishbone slave
   // ***************************************************************
   // Ack one cycle after the strobe; commit on the edge the master sees ack
   assign bus_req = wb_cyc_i && wb_stb_i;
   assign bus_commit = bus_req && wb_ack_o;
   assign wr_commit = bus_commit && wb_we_i && wb_sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req && !wb_ack_o;
      end
   end

   // Read mux; unmapped addresses answer zero
   always_comb begin
      unique case (wb_adr_i)
         ADR_SYSCTL: rd_byte = sysctl_r;
         ADR_CLKDIV: rd_byte = clkdiv_r;
         ADR_MODSTBY_HI: rd_byte = modstby_hi_r | MODSTBY_HI_ONES;
         ADR_MODSTBY_LO: rd_byte = modstby_lo_r;
         ADR_STATUS: rd_byte = {4'h0, settle_busy, state_r};
         default: rd_byte = 8'h00;
      endcase
   end

   // Data is captured with ack so it stands while ack is high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else begin
         wb_dat_o <= {24'h000000, rd_byte};
      end
   end

   // ***************************************************************
   // Control registers
   // ***************************************************************
   // Software standby keeps every register; only reset or hardware standby clears
   always_ff @(posedge clk_i) begin
      if (hw_clear) begin
         sysctl_r <= SYSCTL_RST;
      end else if (wr_commit && wb_adr_i == ADR_SYSCTL) begin
         sysctl_r <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (hw_clear) begin
         clkdiv_r <= CLKDIV_RST;
      end else if (wr_commit && wb_adr_i == ADR_CLKDIV) begin
         clkdiv_r <= wb_dat_i[7:0] | CLKDIV_ONES;
      end
   end

   always_ff @(posedge clk_i) begin
      if (hw_clear) begin
         modstby_hi_r <= MODSTBY_HI_RST;
      end else if (wr_commit && wb_adr_i == ADR_MODSTBY_HI) begin
         modstby_hi_r <= wb_dat_i[7:0] | MODSTBY_HI_ONES;
      end
   end

   // cleared by reset and hardware standby
   always_ff @(posedge clk_i) begin
      if (hw_clear) begin
         modstby_lo_r <= MODSTBY_LO_RST;
      end else if (wr_commit && wb_adr_i == ADR_MODSTBY_LO) begin
         modstby_lo_r <= wb_dat_i[7:0];
      end
   end

   // ***************************************************************
   // Power mode state machine
   // ***************************************************************
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         PDM_RUN: begin
            if (halt_exec_i && !sysctl_r.standby_select) begin
               state_nxt = PDM_SLEEP;
            end else if (halt_exec_i) begin
               state_nxt = PDM_SW_STANDBY_INPUT_PIN;
            end
         end
         PDM_SLEEP: begin
            if (sleep_wake_i) begin
               state_nxt = PDM_RUN;
            end
         end
         PDM_SW_STANDBY_INPUT_PIN: begin
            if (standby_input_pin_wake_i) begin
               state_nxt = PDM_SETTLE;
            end
         end
         PDM_SETTLE: begin
            if (settle_done) begin
               state_nxt = PDM_RUN;
            end
         end
         PDM_HW_STANDBY_INPUT_PIN: begin
            state_nxt = PDM_HW_STANDBY_INPUT_PIN;
         end
      endcase
   end

   // reset pin and standby pin exits
   // standby pin wins over all but reset
   // reset clocks the chip at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= PDM_RUN;
      end else if (!standby_pin_n_i) begin
         state_r <= PDM_HW_STANDBY_INPUT_PIN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // restart oscillator and start the wait
   assign settle_start = state_r == PDM_SW_STANDBY_INPUT_PIN && standby_input_pin_wake_i && standby_pin_n_i;
   pdm_settle_timer #(
      .SHIFT(SETTLE_SHIFT)
   ) u_settle (
      .clk_i(clk_i),
      .rst_i(hw_clear),
      .start_i(settle_start),
      .code_i(sysctl_r.settle_time_select),
      .busy_o(settle_busy),
      .done_o(settle_done)
   );

   // ***************************************************************
   // Mode outputs
   // ***************************************************************
   // Registered from the next state so they line up with the state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_clk_en_o <= 1'b1;
         osc_run_o <= 1'b1;
         int_start_o <= 1'b0;
         refresh_clear_o <= 1'b0;
      end else if (!standby_pin_n_i) begin
         cpu_clk_en_o <= 1'b0;
         osc_run_o <= 1'b0;
         int_start_o <= 1'b0;
         refresh_clear_o <= 1'b0;
      end else begin
         // CPU halts in sleep and standby
         cpu_clk_en_o <= state_nxt == PDM_RUN;
         osc_run_o <= state_nxt != PDM_SW_STANDBY_INPUT_PIN;
         int_start_o <= state_nxt == PDM_RUN
            && (state_r == PDM_SLEEP || state_r == PDM_SETTLE);
         refresh_clear_o <= state_r == PDM_RUN && state_nxt == PDM_SW_STANDBY_INPUT_PIN;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_out_oe_o <= 1'b1;
         clk_out_high_o <= 1'b0;
      end else begin
         // stop bit gates the pin driver
         clk_out_oe_o <= !modstby_hi_r[HI_CLK_STOP_BIT] && state_r != PDM_HW_STANDBY_INPUT_PIN && !hw_clear;
         clk_out_high_o <= state_r == PDM_SW_STANDBY_INPUT_PIN || state_r == PDM_SETTLE;
      end
   end

   // Plain copies of control fields for the rest of the chip
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_hold_o <= 1'b0;
         nmi_edge_select_o <= 1'b0;
         clock_divide_o <= 2'h0;
      end else begin
         port_hold_o <= sysctl_r.port_hold;
         nmi_edge_select_o <= sysctl_r.nmi_edge_select;
         clock_divide_o <= clkdiv_r[1:0];
      end
   end

   // ***************************************************************
   // Module standby
   // ***************************************************************
   // serial channel bits in the low three, the other modules above from the low register
   assign standby_vec = {modstby_lo_r[LO_ADC_BIT], modstby_lo_r[LO_T8B_BIT],
      modstby_lo_r[LO_T8A_BIT], modstby_lo_r[LO_T16_BIT], modstby_lo_r[LO_DRAM_BIT],
      modstby_lo_r[LO_DMA_BIT], modstby_hi_r[2:0]};

   assign stop_vec = (state_r == PDM_SW_STANDBY_INPUT_PIN || state_r == PDM_SETTLE
      || state_r == PDM_HW_STANDBY_INPUT_PIN) ? '1 : '0;

   // software standby resets all but the DRAM interface, which keeps settings; hardware standby resets all
   always_comb begin
      reset_vec = stop_vec;
      if (state_r != PDM_HW_STANDBY_INPUT_PIN) begin
         reset_vec[MOD_DRAM] = 1'b0;
      end
   end
   pdm_mod_gate u_gate (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .standby_i(standby_vec),
      .stop_i(stop_vec),
      .reset_i(reset_vec),
      .periph_sel_i(periph_sel_i),
      .periph_we_i(periph_we_i),
      .periph_rdata_i(periph_rdata_i),
      .mod_clk_en_o(mod_clk_en_o),
      .mod_rst_o(mod_rst_o),
      .periph_we_o(periph_we_o),
      .periph_rdata_o(periph_rdata_o)
   );

   // ***************************************************************
   // Checks
   // ***************************************************************
   sequence s_run_halt(logic sel);
      state_r == PDM_RUN && halt_exec_i && sysctl_r.standby_select == sel
         && standby_pin_n_i;
   endsequence
   sequence s_settle_exit;
      state_r == PDM_SETTLE && settle_done && standby_pin_n_i ##1 state_r == PDM_RUN;
   endsequence

   a_clkout_stop: assert property (modstby_hi_r[HI_CLK_STOP_BIT] |=> !clk_out_oe_o)
      else $error("clock pin driven while stopped");
   a_hi_ones: assert property ((modstby_hi_r & MODSTBY_HI_ONES) == MODSTBY_HI_ONES)
      else $error("reserved high bits not one");
   a_lo_write: assert property (wr_commit && wb_adr_i == ADR_MODSTBY_LO
      && standby_pin_n_i |=> modstby_lo_r == $past(wb_dat_i[7:0]))
      else $error("low standby register did not store write");
   a_sleep_entry: assert property (s_run_halt(1'b0) |=> state_r == PDM_SLEEP
      && !cpu_clk_en_o)
      else $error("halt with select clear did not sleep");
   // A wake may follow entry at once, so the oscillator is checked in the first cycle
   a_soft_entry: assert property (s_run_halt(1'b1) |=> state_r == PDM_SW_STANDBY_INPUT_PIN
      && refresh_clear_o && !osc_run_o ##1 !refresh_clear_o)
      else $error("software standby entry wrong");
   a_sleep_wake: assert property (state_r == PDM_SLEEP && sleep_wake_i
      && standby_pin_n_i |=> state_r == PDM_RUN && int_start_o && cpu_clk_en_o)
      else $error("sleep wake not taken");
   a_standby_input_pin_hold: assert property (state_r == PDM_SW_STANDBY_INPUT_PIN && !standby_input_pin_wake_i
      && standby_pin_n_i |=> state_r == PDM_SW_STANDBY_INPUT_PIN)
      else $error("software standby left without wake");
   a_settle_gate: assert property (state_r == PDM_SETTLE |-> !cpu_clk_en_o
      && mod_clk_en_o == '0)
      else $error("clocks released during settle wait");
   a_select_kept: assert property (s_settle_exit |-> sysctl_r.standby_select
      && int_start_o)
      else $error("standby select lost on interrupt wake");
   a_hw_standby: assert property (!standby_pin_n_i |=> state_r == PDM_HW_STANDBY_INPUT_PIN
      && modstby_lo_r == 8'h00 && !clk_out_oe_o ##1 !cpu_clk_en_o)
      else $error("standby pin did not enter hardware standby");
   a_sleep_mods: assert property (state_r == PDM_SLEEP && standby_vec == '0
      && standby_pin_n_i |=> mod_clk_en_o == '1)
      else $error("modules stopped in sleep");
endmodule

// ==== testbench/pdm_periph_model.sv ====
// Behavioural model of the gated peripherals answering register reads
module pdm_periph_model
   import pdm_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Access from the controller
   input wire logic [NUM_MODS-1:0] sel_i,
   output logic [7:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] idle_r = 8'h00;
   // Unselected bus floats, so show a value that flips every cycle
   always @(posedge clk_i) begin
      idle_r <= ~idle_r;
   end
   always_comb begin
      rdata_o = idle_r;
      for (int i = 0; i < NUM_MODS; i++) begin
         if (sel_i[i]) begin
            rdata_o = 8'ha0 | 8'(i);
         end
      end
   end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the power-down controller
module tb_top
   import pdm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} pdm_row_type;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pwe = 1'b0;
   logic pin_n = 1'b1, halt = 1'b0, swake = 1'b0, bwake = 1'b0;
   logic [7:0] adr = 8'h00, prd, prd_o;
   logic [31:0] dat = 32'h0, dat_o, rd;
   logic [8:0] psel = 9'h000, clk_en, mrst;
   logic ack, cpu, int_st, osc, rclr, oe, pwe_o, chigh, phold, nmis;
   logic [1:0] cdiv;
   int mismatches = 0, check_count = 0, k;
   pdm_row_type rows [10] = '{
      '{1'b0, ADR_SYSCTL, 8'h00, SYSCTL_RST}, '{1'b0, ADR_CLKDIV, 8'h00, CLKDIV_RST},
      '{1'b0, ADR_MODSTBY_HI, 8'h00, 8'h78}, '{1'b0, ADR_MODSTBY_LO, 8'h00, 8'h00},
      '{1'b1, ADR_MODSTBY_HI, 8'hff, 8'hff}, '{1'b1, ADR_MODSTBY_HI, 8'h00, 8'h78},
      '{1'b1, ADR_MODSTBY_LO, 8'h42, 8'h42}, '{1'b1, ADR_MODSTBY_LO, 8'hbd, 8'hbd},
      '{1'b1, ADR_CLKDIV, 8'h03, 8'hff}, '{1'b1, 8'h14, 8'hff, 8'h00}};
   // Clock at 25 MHz
   always #20 clk_i = ~clk_i;
   pdm_power_ctrl #(.SETTLE_SHIFT(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .standby_pin_n_i(pin_n), .halt_exec_i(halt),
      .sleep_wake_i(swake), .standby_input_pin_wake_i(bwake), .cpu_clk_en_o(cpu), .int_start_o(int_st),
      .osc_run_o(osc), .refresh_clear_o(rclr), .port_hold_o(phold), .nmi_edge_select_o(nmis),
      .clock_divide_o(cdiv), .clk_out_oe_o(oe), .clk_out_high_o(chigh), .periph_sel_i(psel),
      .periph_we_i(pwe), .periph_rdata_i(prd), .mod_clk_en_o(clk_en), .mod_rst_o(mrst),
      .periph_we_o(pwe_o), .periph_rdata_o(prd_o));
   pdm_periph_model u_periph (.clk_i(clk_i), .sel_i(psel), .rdata_o(prd));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled, then release; only the watchdog
   // ends a wait that never gets an answer
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic do_halt();
      @(posedge clk_i);
      halt <= 1'b1;
      @(posedge clk_i);
      halt <= 1'b0;
      @(posedge clk_i);
   endtask
   // Bounded wait for the start of interrupt handling
   task automatic wait_int();
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (int_st !== 1'b1 && k < 2000);
   endtask
   task automatic conclude();
      if (mismatches == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Watchdog far beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wb(1'b1, rows[i].a, rows[i].d);
         end
         wb(1'b0, rows[i].a, 8'h00);
         chk("reg", {24'h0, rows[i].e}, rd);
      end
      wb(1'b1, ADR_MODSTBY_HI, 8'h85);
      wb(1'b1, ADR_MODSTBY_LO, 8'h91);
      repeat (2) @(posedge clk_i);
      chk("gate", 9'h0d2, clk_en);
      chk("hold", 9'h12d, mrst);
      chk("oe", 1'b0, oe);
      chk("clow", 1'b0, chigh);
      psel <= 9'h008;
      pwe <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("prd", 8'hff, prd_o);
      chk("pwe", 1'b0, pwe_o);
      psel <= 9'h002;
      repeat (2) @(posedge clk_i);
      chk("prd", 8'ha1, prd_o);
      chk("pwe", 1'b1, pwe_o);
      wb(1'b1, ADR_SYSCTL, 8'h0f);
      do_halt();
      chk("cpu", 1'b0, cpu);
      chk("phold", 1'b1, phold);
      chk("nmis", 1'b1, nmis);
      chk("cdiv", 2'h3, cdiv);
      wb(1'b0, ADR_STATUS, 8'h00);
      chk("mode", 32'h1, rd);
      swake <= 1'b1;
      wait_int();
      swake <= 1'b0;
      chk("swake", 2, k);
      // Settle code 6 gives 1024 states, shortened by the shift to 4; the clock is
      // external, and watchdog and bus release are never enabled before standby
      wb(1'b1, ADR_SYSCTL, 8'he9);
      do_halt();
      chk("rclr", 1'b1, rclr);
      chk("osc", 1'b0, osc);
      @(posedge clk_i);
      chk("mstop", 9'h000, clk_en);
      chk("chigh", 1'b1, chigh);
      bwake <= 1'b1;
      wait_int();
      bwake <= 1'b0;
      chk("settle", 1'b1, k >= 5 && k <= 9);
      wb(1'b0, ADR_SYSCTL, 8'h00);
      chk("sel", 32'he9, rd);
      do_halt();
      pin_n <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("hwosc", 1'b0, osc);
      chk("hwoe", 1'b0, oe);
      wb(1'b0, ADR_MODSTBY_LO, 8'h00);
      chk("hwlo", 32'h0, rd);
      wb(1'b0, ADR_STATUS, 8'h00);
      chk("hwmode", 32'h4, rd);
      // Only the reset pin leaves hardware standby; clocks return while it is held
      rst_i <= 1'b1;
      pin_n <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("rcpu", 1'b1, cpu);
      chk("rosc", 1'b1, osc);
      chk("roe", 1'b1, oe);
      chk("rgate", 9'h1ff, clk_en);
      rst_i <= 1'b0;
      wb(1'b0, ADR_STATUS, 8'h00);
      chk("rmode", 32'h0, rd);
      conclude();
   end
endmodule
